// [hw/regulator_enable_control.sv]
`timescale 1ns/1ps

module regulator_enable_control
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port from the serial control interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    // multipurpose control pins, asynchronous
    input wire logic [7:0] multipurpose_control_pin,
    // supply and boot sequencer status, same clock
    input wire logic supply_present,
    input wire logic boot_0_reached,
    input wire logic boot_25_reached,
    input wire logic boot_50_reached,
    input wire logic boot_100_reached,
    // regulator controls
    output logic reg1_enable,
    output logic reg2_enable,
    output logic [4:0] reg1_voltage_code,
    output logic [11:0] reg1_voltage_mv
);

    logic [7:0] reg1_enable_config_ff;
    logic [7:0] reg1_voltage_code_ff;
    logic [7:0] reg1_pin_select_mask_ff;
    logic [7:0] reg2_enable_config_ff;
    logic [7:0] reg2_pin_select_mask_ff;
    logic [7:0] pin_meta_ff;
    logic [7:0] pin_sync_ff;
    logic [7:0] nxt_rd_data;
    logic [7:0] rd_data_ff;
    logic [11:0] nxt_voltage_mv;
    logic [11:0] voltage_mv_ff;

    // =====================================================================
    // per-regulator configuration bundles
    regulator_ctrl_if reg1_ctrl ();
    regulator_ctrl_if reg2_ctrl ();

    // =====================================================================
    // field and address helpers, shared by both regulators
    function automatic logic [2:0] seq_of(input logic [7:0] cfg);
        seq_of = cfg[regulator_enable_pkg::SEQ_MSB:regulator_enable_pkg::SEQ_LSB];
    endfunction : seq_of

    function automatic logic [1:0] mode_of(input logic [7:0] cfg);
        mode_of = cfg[regulator_enable_pkg::MODE_MSB:regulator_enable_pkg::MODE_LSB];
    endfunction : mode_of

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = reg_wr_en && (addr == target);
    endfunction : hit

    // =====================================================================
    // pin synchroniser
    // pins are asynchronous; the first stage may go metastable,
    // so only the second stage feeds the enable decoders
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_ff <= regulator_enable_pkg::RST_PIN_LEVELS;
            pin_sync_ff <= regulator_enable_pkg::RST_PIN_LEVELS;
        end
        else
        begin
            pin_meta_ff <= multipurpose_control_pin;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // =====================================================================
    // register writes; unused bits are held at zero
    // first regulator: enable config, voltage code, pin mask
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg1_enable_config_ff <= regulator_enable_pkg::RST_ENABLE_CONFIG;
        else if (hit(reg_addr, regulator_enable_pkg::ADDR_REG1_ENABLE_CONFIG))
            reg1_enable_config_ff <= reg_wr_data & regulator_enable_pkg::ENABLE_CONFIG_MASK;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg1_voltage_code_ff <= regulator_enable_pkg::RST_VOLTAGE_CODE;
        else if (hit(reg_addr, regulator_enable_pkg::ADDR_REG1_VOLTAGE_CODE))
            reg1_voltage_code_ff <= reg_wr_data & regulator_enable_pkg::VOLTAGE_CODE_MASK;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg1_pin_select_mask_ff <= regulator_enable_pkg::RST_PIN_SELECT;
        else if (hit(reg_addr, regulator_enable_pkg::ADDR_REG1_PIN_SELECT))
            reg1_pin_select_mask_ff <= reg_wr_data;
    end

    // second regulator: enable config and pin mask
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg2_enable_config_ff <= regulator_enable_pkg::RST_ENABLE_CONFIG;
        else if (hit(reg_addr, regulator_enable_pkg::ADDR_REG2_ENABLE_CONFIG))
            reg2_enable_config_ff <= reg_wr_data & regulator_enable_pkg::ENABLE_CONFIG_MASK;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg2_pin_select_mask_ff <= regulator_enable_pkg::RST_PIN_SELECT;
        else if (hit(reg_addr, regulator_enable_pkg::ADDR_REG2_PIN_SELECT))
            reg2_pin_select_mask_ff <= reg_wr_data;
    end

    // =====================================================================
    // read back, registered; unmapped addresses read zero
    // one cycle of latency keeps reg_rd_data straight from a flop
    always_comb
    begin
        case (reg_addr)
            regulator_enable_pkg::ADDR_REG1_ENABLE_CONFIG: nxt_rd_data = reg1_enable_config_ff;
            regulator_enable_pkg::ADDR_REG1_VOLTAGE_CODE: nxt_rd_data = reg1_voltage_code_ff;
            regulator_enable_pkg::ADDR_REG1_PIN_SELECT: nxt_rd_data = reg1_pin_select_mask_ff;
            regulator_enable_pkg::ADDR_REG2_ENABLE_CONFIG: nxt_rd_data = reg2_enable_config_ff;
            regulator_enable_pkg::ADDR_REG2_PIN_SELECT: nxt_rd_data = reg2_pin_select_mask_ff;
            default: nxt_rd_data = regulator_enable_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_ff <= regulator_enable_pkg::RST_READ_DATA;
        else
            rd_data_ff <= nxt_rd_data;
    end

    // =====================================================================
    // voltage in millivolts, linear in the code
    // top code gives 4000 mV, which still fits the 12-bit result
    always_comb
    begin
        nxt_voltage_mv = regulator_enable_pkg::VOUT_BASE_MV
            + 12'(reg1_voltage_code_ff[regulator_enable_pkg::VCODE_W-1:0] * regulator_enable_pkg::VOUT_STEP_MV);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        // code resets to zero, so the scale starts at its base
        if (!rst_n)
            voltage_mv_ff <= regulator_enable_pkg::VOUT_BASE_MV;
        else
            voltage_mv_ff <= nxt_voltage_mv;
    end

    // =====================================================================
    // enable decoders; only the first regulator has the supply-on code
    // both decoders see the same synchronised pins, so a pin edge
    // reaches the two enables on the same clock
    // supply-on is refused for the second regulator by its tie-off
    assign reg1_ctrl.seq = seq_of(reg1_enable_config_ff);
    assign reg1_ctrl.mode = mode_of(reg1_enable_config_ff);
    assign reg1_ctrl.mask = reg1_pin_select_mask_ff;
    assign reg1_ctrl.supply_code_allowed = 1'b1;
    assign reg2_ctrl.seq = seq_of(reg2_enable_config_ff);
    assign reg2_ctrl.mode = mode_of(reg2_enable_config_ff);
    assign reg2_ctrl.mask = reg2_pin_select_mask_ff;
    assign reg2_ctrl.supply_code_allowed = 1'b0;

    regulator_enable_decode u_reg1_decode
    (
        .clk(clk),
        .rst_n(rst_n),
        .pins(pin_sync_ff),
        .supply_present(supply_present),
        .boot_0_reached(boot_0_reached),
        .boot_25_reached(boot_25_reached),
        .boot_50_reached(boot_50_reached),
        .boot_100_reached(boot_100_reached),
        .ctrl(reg1_ctrl)
    );

    regulator_enable_decode u_reg2_decode
    (
        .clk(clk),
        .rst_n(rst_n),
        .pins(pin_sync_ff),
        .supply_present(supply_present),
        .boot_0_reached(boot_0_reached),
        .boot_25_reached(boot_25_reached),
        .boot_50_reached(boot_50_reached),
        .boot_100_reached(boot_100_reached),
        .ctrl(reg2_ctrl)
    );

    // =====================================================================
    // outputs
    assign reg_rd_data = rd_data_ff;
    assign reg1_enable = reg1_ctrl.enable;
    assign reg2_enable = reg2_ctrl.enable;
    assign reg1_voltage_code = reg1_voltage_code_ff[regulator_enable_pkg::VCODE_W-1:0];
    assign reg1_voltage_mv = voltage_mv_ff;

endmodule : regulator_enable_control

// [include/regulator_enable_pkg.sv]
package regulator_enable_pkg;

    // =====================================================================
    // register offsets
    localparam logic [7:0] ADDR_REG1_ENABLE_CONFIG = 8'h5a;
    localparam logic [7:0] ADDR_REG1_VOLTAGE_CODE = 8'h5c;
    localparam logic [7:0] ADDR_REG1_PIN_SELECT = 8'h5d;
    localparam logic [7:0] ADDR_REG2_ENABLE_CONFIG = 8'h5e;
    localparam logic [7:0] ADDR_REG2_PIN_SELECT = 8'h61;

    // =====================================================================
    // reset values
    localparam logic [7:0] RST_ENABLE_CONFIG = 8'h00;
    localparam logic [7:0] RST_VOLTAGE_CODE = 8'h00;
    localparam logic [7:0] RST_PIN_SELECT = 8'h00;
    localparam logic [7:0] RST_PIN_LEVELS = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // =====================================================================
    // field layout of the enable configuration, voltage code and pin select registers
    localparam int SEQ_MSB = 7;
    localparam int SEQ_LSB = 5;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;
    localparam logic [7:0] ENABLE_CONFIG_MASK = 8'he3;
    localparam logic [7:0] VOLTAGE_CODE_MASK = 8'h1f;
    localparam int VCODE_W = 5;
    localparam int PIN_COUNT = 8;

    // =====================================================================
    // sequencing codes
    typedef logic [2:0] seq_t;
    localparam seq_t SEQ_DISABLED = 3'h0;
    localparam seq_t SEQ_SUPPLY_ON = 3'h1;
    localparam seq_t SEQ_BOOT_0 = 3'h2;
    localparam seq_t SEQ_BOOT_25 = 3'h3;
    localparam seq_t SEQ_BOOT_50 = 3'h4;
    localparam seq_t SEQ_BY_MODE = 3'h7;

    // enable mode codes
    typedef logic [1:0] mode_t;
    localparam mode_t MODE_OFF = 2'h0;
    localparam mode_t MODE_ON = 2'h1;
    localparam mode_t MODE_PIN = 2'h2;

    // =====================================================================
    // voltage scale in millivolts
    localparam int VOUT_W = 12;
    localparam logic [11:0] VOUT_BASE_MV = 12'h384;
    localparam logic [11:0] VOUT_STEP_MV = 12'h064;

endpackage : regulator_enable_pkg

// [include/regulator_ctrl_if.sv]
`timescale 1ns/1ps

interface regulator_ctrl_if;
    logic [2:0] seq;
    logic [1:0] mode;
    logic [7:0] mask;
    logic supply_code_allowed;
    logic enable;

    modport owner (output seq, output mode, output mask, output supply_code_allowed, input enable);
    modport decoder (input seq, input mode, input mask, input supply_code_allowed, output enable);
endinterface : regulator_ctrl_if

// [hw/regulator_enable_decode.sv]
`timescale 1ns/1ps

module regulator_enable_decode
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // shared status, already synchronised
    input wire logic [7:0] pins,
    input wire logic supply_present,
    input wire logic boot_0_reached,
    input wire logic boot_25_reached,
    input wire logic boot_50_reached,
    input wire logic boot_100_reached,
    // per-regulator configuration
    regulator_ctrl_if.decoder ctrl
);

    logic nxt_enable;
    logic enable_ff;

    // =====================================================================
    // enable decode
    always_comb
    begin
        nxt_enable = 1'b0;
        case (ctrl.seq)
            regulator_enable_pkg::SEQ_DISABLED: nxt_enable = 1'b0;
            regulator_enable_pkg::SEQ_SUPPLY_ON: nxt_enable = ctrl.supply_code_allowed & supply_present;
            regulator_enable_pkg::SEQ_BOOT_0: nxt_enable = boot_0_reached;
            regulator_enable_pkg::SEQ_BOOT_25: nxt_enable = boot_25_reached;
            regulator_enable_pkg::SEQ_BOOT_50: nxt_enable = boot_50_reached;
            regulator_enable_pkg::SEQ_BY_MODE:
            begin
                // mode field only counts once the boot delay is complete
                case (ctrl.mode)
                    regulator_enable_pkg::MODE_OFF: nxt_enable = 1'b0;
                    regulator_enable_pkg::MODE_ON: nxt_enable = boot_100_reached;
                    regulator_enable_pkg::MODE_PIN: nxt_enable = boot_100_reached & (|(ctrl.mask & pins));
                    default: nxt_enable = 1'b0;
                endcase
            end
            default: nxt_enable = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            enable_ff <= 1'b0;
        else
            enable_ff <= nxt_enable;
    end

    assign ctrl.enable = enable_ff;

endmodule : regulator_enable_decode

// [sim/regulator_enable_properties.sv]
`timescale 1ns/1ps

// ==========
// shadow registers and port checks
module regulator_enable_properties
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    // pins and status
    input wire logic [7:0] multipurpose_control_pin,
    input wire logic supply_present,
    input wire logic boot_0_reached,
    input wire logic boot_25_reached,
    input wire logic boot_50_reached,
    input wire logic boot_100_reached,
    // regulator controls
    input wire logic reg1_enable,
    input wire logic reg2_enable,
    input wire logic [4:0] reg1_voltage_code,
    input wire logic [11:0] reg1_voltage_mv
);
    logic [7:0] cfg1_ff, vc_ff, msk1_ff, cfg2_ff, msk2_ff, s1_ff, s2_ff;
    logic exp1, exp2;
    logic [7:0] exp_rd;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg1_ff <= 8'h00;
            vc_ff <= 8'h00;
            msk1_ff <= 8'h00;
            cfg2_ff <= 8'h00;
            msk2_ff <= 8'h00;
        end
        else if (reg_wr_en)
        begin
            case (reg_addr)
                8'h5a: cfg1_ff <= reg_wr_data & 8'he3;
                8'h5c: vc_ff <= reg_wr_data & 8'h1f;
                8'h5d: msk1_ff <= reg_wr_data;
                8'h5e: cfg2_ff <= reg_wr_data & 8'he3;
                8'h61: msk2_ff <= reg_wr_data;
                default: ;
            endcase
        end
    end

    // same two-stage delay as the pin synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= 8'h00;
            s2_ff <= 8'h00;
        end
        else
        begin
            s1_ff <= multipurpose_control_pin;
            s2_ff <= s1_ff;
        end
    end

    function automatic logic en_f(input logic second, input logic [7:0] c, input logic [7:0] k);
        case (c[7:5])
            3'h1: return !second && supply_present;
            3'h2: return boot_0_reached;
            3'h3: return boot_25_reached;
            3'h4: return boot_50_reached;
            3'h7: return boot_100_reached && (c[1:0] == 2'h1 || (c[1:0] == 2'h2 && (k & s2_ff) != 8'h00));
            default: return 1'b0;
        endcase
    endfunction : en_f

    // en_f reads status and pins beyond its arguments, so a plain assign would go stale
    always_comb
    begin
        exp1 = en_f(1'b0, cfg1_ff, msk1_ff);
        exp2 = en_f(1'b1, cfg2_ff, msk2_ff);
    end

    always_comb
    begin
        case (reg_addr)
            8'h5a: exp_rd = cfg1_ff;
            8'h5c: exp_rd = vc_ff;
            8'h5d: exp_rd = msk1_ff;
            8'h5e: exp_rd = cfg2_ff;
            8'h61: exp_rd = msk2_ff;
            default: exp_rd = 8'h00;
        endcase
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_volt_scale: assert property (1'b1 |=> reg1_voltage_mv == 12'h384 + 12'h064 * $past(reg1_voltage_code))
        else $error("voltage in millivolts off scale");
    a_vcode_write: assert property (reg_wr_en && reg_addr == 8'h5c |=> reg1_voltage_code == $past(reg_wr_data[4:0]))
        else $error("voltage code not stored");
    a_read_back: assert property (1'b1 |=> reg_rd_data == $past(exp_rd))
        else $error("read data wrong");
    a_cfg_fields: assert property (reg_wr_en && reg_addr == 8'h5e ##1 reg_addr == 8'h5e |=> reg_rd_data == ($past(reg_wr_data, 2) & 8'he3))
        else $error("second config fields wrong");
    a_first_enable: assert property (1'b1 |=> reg1_enable == $past(exp1))
        else $error("first enable wrong");
    a_second_enable: assert property (1'b1 |=> reg2_enable == $past(exp2))
        else $error("second enable wrong");
    a_rsvd_seq_off: assert property ((cfg1_ff[7:5] == 3'h5 || cfg1_ff[7:5] == 3'h6) |=> !reg1_enable)
        else $error("reserved sequencing enabled");
    a_rsvd_mode_off: assert property (cfg2_ff[7:5] == 3'h7 && cfg2_ff[1:0] == 2'h3 |=> !reg2_enable)
        else $error("reserved mode enabled");
    a_empty_mask: assert property (cfg1_ff == 8'he2 && msk1_ff == 8'h00 |=> !reg1_enable)
        else $error("empty mask enabled");

    c_first_on: cover property ($rose(reg1_enable));
    c_second_on: cover property ($rose(reg2_enable));
    c_vcode_top: cover property (reg1_voltage_code == 5'h1f);
endmodule : regulator_enable_properties

bind regulator_enable_control regulator_enable_properties i_props (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .multipurpose_control_pin(multipurpose_control_pin), .supply_present(supply_present),
    .boot_0_reached(boot_0_reached), .boot_25_reached(boot_25_reached), .boot_50_reached(boot_50_reached),
    .boot_100_reached(boot_100_reached), .reg1_enable(reg1_enable), .reg2_enable(reg2_enable),
    .reg1_voltage_code(reg1_voltage_code), .reg1_voltage_mv(reg1_voltage_mv));

// [sim/control_pin_model.sv]
`timescale 1ns/1ps

// ==========
// pin and boot-status source
module control_pin_model
(
    // clock
    input wire logic clk,
    // levels asked for
    input wire logic [7:0] pin_req,
    input wire logic [2:0] stage,
    input wire logic supply_req,
    // levels seen by the device
    output logic [7:0] pins = 8'h00,
    output logic supply = 1'b0,
    output logic [3:0] boot = 4'h0
);
    // moves only on the falling edge, away from sampling
    always @(negedge clk)
    begin
        pins <= pin_req;
        supply <= supply_req;
        boot <= {stage > 3'h3, stage > 3'h2, stage > 3'h1, stage > 3'h0};
    end
endmodule : control_pin_model

// [sim/test_regulator_enable_control.sv]
`timescale 1ns/1ps

// ==========
// register and enable tests
module test_regulator_enable_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en = 1'b0;
    logic supply_req = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] pin_req = 8'h00;
    logic [2:0] stage = 3'h0;
    logic [7:0] pins, rdata;
    logic [3:0] boot;
    logic supply, en1, en2;
    logic [4:0] vcode;
    logic [11:0] vmv;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] maps [7] = '{8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h60, 8'h61};
    logic [7:0] codes [4] = '{8'h00, 8'h01, 8'hfe, 8'hff};

    always #20 clk = ~clk;

    regulator_enable_control i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wdata), .reg_rd_data(rdata), .multipurpose_control_pin(pins), .supply_present(supply),
        .boot_0_reached(boot[0]), .boot_25_reached(boot[1]), .boot_50_reached(boot[2]),
        .boot_100_reached(boot[3]), .reg1_enable(en1), .reg2_enable(en2), .reg1_voltage_code(vcode),
        .reg1_voltage_mv(vmv));
    control_pin_model i_pins (.clk(clk), .pin_req(pin_req), .stage(stage), .supply_req(supply_req),
        .pins(pins), .supply(supply), .boot(boot));

    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(rdata, e, "read");
    endtask : rd

    function automatic logic exp_en(input logic second, input logic [2:0] s, input logic [1:0] m,
        input logic [7:0] k, input logic [7:0] p, input logic [2:0] st);
        case (s)
            3'h1: return !second && supply_req;
            3'h2: return st > 3'h0;
            3'h3: return st > 3'h1;
            3'h4: return st > 3'h2;
            3'h7: return st > 3'h3 && (m == 2'h1 || (m == 2'h2 && (k & p) != 8'h00));
            default: return 1'b0;
        endcase
    endfunction : exp_en

    task automatic run(input logic [2:0] s, input logic [1:0] m, input logic [7:0] k, input logic [7:0] p,
        input logic [2:0] st);
        wr(8'h5a, {s, 3'h0, m});
        wr(8'h5d, k);
        wr(8'h5e, {s, 3'h0, m});
        wr(8'h61, k);
        pin_req = p;
        stage = st;
        // covers the two-flop pin path plus the enable flop
        repeat (5) @(negedge clk);
        check(en1, exp_en(1'b0, s, m, k, p, st), "first enable");
        check(en2, exp_en(1'b1, s, m, k, p, st), "second enable");
    endtask : run

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            $display("mismatch at %0t: run timed out", $time);
            results();
        end
    end

    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        foreach (maps[i]) rd(maps[i], 8'h00);
        check(vmv, 12'h384, "reset voltage");
        wr(8'h60, 8'hff);
        rd(8'h60, 8'h00);
        wr(8'h5e, 8'hff);
        rd(8'h5e, 8'he3);
        foreach (codes[i])
        begin
            wr(8'h5c, codes[i]);
            rd(8'h5c, codes[i] & 8'h1f);
            check(vcode, codes[i] & 8'h1f, "voltage code");
            check(vmv, 12'h384 + 12'h064 * codes[i][4:0], "voltage");
        end
        $display("test registers done");
        for (int s = 0; s < 8; s++)
            for (int t = 2; t < 5; t++)
                run(3'(s), 2'h1, 8'h00, 8'h00, 3'(t));
        supply_req = 1'b0;
        run(3'h1, 2'h1, 8'h00, 8'h00, 3'h4);
        supply_req = 1'b1;
        $display("test sequencing done");
        for (int m = 0; m < 4; m++)
            run(3'h7, 2'(m), 8'h81, 8'h80, 3'h4);
        for (int i = 0; i < 8; i++)
        begin
            run(3'h7, 2'h2, 8'h01 << i, 8'h01 << i, 3'h4);
            run(3'h7, 2'h2, 8'h01 << i, ~(8'h01 << i), 3'h4);
        end
        run(3'h7, 2'h2, 8'h00, 8'hff, 3'h4);
        run(3'h7, 2'h2, 8'hff, 8'h10, 3'h4);
        run(3'h2, 2'h2, 8'hff, 8'hff, 3'h0);
        run(3'h7, 2'h2, 8'hff, 8'hff, 3'h3);
        $display("test pin control done");
        results();
    end
endmodule : test_regulator_enable_control
